/* eep_pkg.sv */
// Shared constants and state codes for the serial EEPROM slave engine
package eep_pkg;
   // Array geometry: 64 Kbit as 8192 bytes, rows of 32 bytes
   localparam int ADDR_W = 13;
   localparam int PAGE_W = 5;
   localparam int PAGE_BYTES = 32;
   localparam logic [7:0] MEM_INIT = 8'hFF;
   // Protected top quarter: two highest array address bits both set
   localparam logic [1:0] TOP_QTR = 2'h3;
   // Bit slot counting within one byte
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Self-timed write cycle length
   localparam int CLK_MHZ = 50;
   localparam int T_WR_US = 5000;
   localparam int T_WR_CYC = T_WR_US * CLK_MHZ;
   localparam int WAIT_W = 20;
   // Protocol states, one-hot
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_DEVSEL = 7'h02,
      ST_ADDR_HI = 7'h04,
      ST_ADDR_LO = 7'h08,
      ST_WDATA = 7'h10,
      ST_RDATA = 7'h20,
      ST_PROG = 7'h40
   } eep_state_type;
endpackage : eep_pkg

/* eep_mem.sv */
// Byte memory with one write port and a registered read port
`timescale 1ns/10ps
module eep_mem #(
   parameter int AW = 13,
   parameter int DW = 8,
   parameter logic [7:0] INIT = 8'hFF
) (
   // Clock
   input wire logic clk,
   // Write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // Read port
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Fresh array content, every byte erased
   initial begin
      for (int i = 0; i < (1 << AW); i++) begin
         mem[i] = INIT[DW-1:0];
      end
   end

   // No reset on the array: contents are non-volatile by intent
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : eep_mem

/* eep_slave.sv */
// Two-wire serial EEPROM slave protocol engine with page latch and array
//
// Operation
// - Start is data falling while clock high; watched except while programming.
// - Stop is data rising while clock high; ends the transfer, to programming after a data acknowledge, else standby.
// - Transmitter releases data after eight bits; receiver pulls low on ninth.
// - Incoming bits are captured on each rising clock edge.
// - Select byte arrives MSB first; top four bits must match the type code.
// - Next three bits must equal the chip select straps, else ignore.
// - Last select bit: one means read, zero means write.
// - Matching select is acknowledged; mismatch releases bus until next start.
// - Write takes high then low address byte, each acknowledged, then data.
// - Protect input high from start to address end blocks top-quarter writes.
// - Programming starts only on stop in the slot after a data acknowledge.
// - While programming, data output stays released and requests are ignored.
// - Select is not acknowledged while programming, acknowledged after it.
// - Page write holds one to thirty-two bytes of one row.
// - Only the five low address bits advance per write byte, wrapping.
// - Reads behave the same whatever the protect input level.
// - Random read: dummy write of address, repeated start, read select.
// - Current read outputs byte at counter, then increments the counter.
// - Master acknowledge asks for next byte; no acknowledge then stop ends.
// - Read counter advances over the whole array, wrapping to zero.
// - Ninth slot sampled after read byte; high means release and standby.
`timescale 1ns/10ps
module eep_slave #(
   parameter int ADDR_W = eep_pkg::ADDR_W,
   parameter int WR_CYCLES = eep_pkg::T_WR_CYC,
   // Device type code; value is arbitrary
   parameter logic [3:0] DEV_TYPE = 4'h5
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Serial bus pins, data is open drain
   input wire logic SCL,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   // Straps and protect input
   input wire logic [2:0] CHIP_SELECT_STRAPS,
   input wire logic WRITE_PROTECT_INPUT,
   // Internal write cycle in progress
   output logic BUSY
);
   localparam int PW = eep_pkg::PAGE_W;
   localparam int PB = eep_pkg::PAGE_BYTES;
   localparam int WW = eep_pkg::WAIT_W;

   // Elaboration checks
   if (ADDR_W < PW + 2 || ADDR_W > 16) begin : g_chk_addr
      $error("ADDR_W out of range");
   end
   if (WR_CYCLES < 1 || WR_CYCLES >= (1 << WW)) begin : g_chk_wait
      $error("WR_CYCLES out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
   logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
   logic wp_meta_reg, wp_sync_reg;
   logic [2:0] cs_meta_reg, cs_sync_reg;
   eep_pkg::eep_state_type state_reg, state_next;
   logic [3:0] cnt_reg, cnt_next;
   logic in_ack_reg, in_ack_next;
   logic ack_bit_reg, ack_bit_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] tx_reg, tx_next;
   logic oe_reg, oe_next;
   logic rw_reg, rw_next;
   logic [7:0] addr_hi_reg, addr_hi_next;
   logic [15:0] waddr_reg, waddr_next;
   logic [ADDR_W-1:0] rd_cnt_reg, rd_cnt_next;
   logic [PB-1:0] valid_reg, valid_next;
   logic wp_seen_reg, wp_seen_next;
   logic slot10_reg, slot10_next;
   logic [PW:0] prog_idx_reg, prog_idx_next;
   logic pw_go_reg, pw_go_next;
   logic [PW-1:0] pw_idx_reg, pw_idx_next;
   logic [WW-1:0] wait_reg, wait_next;
   logic busy_reg, busy_next;
   logic sda_out_reg;
   logic scl_rise, scl_fall, start_cond, stop_cond, protect;
   logic pb_we, mem_we;
   logic [PW-1:0] pb_waddr;
   logic [7:0] pb_wdata, pb_rdata, mem_rdata;
   logic [ADDR_W-1:0] mem_waddr;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and bus condition detection

   // Two flops on every pin before any logic reads it
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         scl_meta_reg <= 1'b1;
         scl_sync_reg <= 1'b1;
         scl_prev_reg <= 1'b1;
         sda_meta_reg <= 1'b1;
         sda_sync_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
         wp_meta_reg <= 1'b0;
         wp_sync_reg <= 1'b0;
         cs_meta_reg <= 3'h0;
         cs_sync_reg <= 3'h0;
      end else begin
         scl_meta_reg <= SCL;
         scl_sync_reg <= scl_meta_reg;
         scl_prev_reg <= scl_sync_reg;
         sda_meta_reg <= SDA_IN;
         sda_sync_reg <= sda_meta_reg;
         sda_prev_reg <= sda_sync_reg;
         wp_meta_reg <= WRITE_PROTECT_INPUT;
         wp_sync_reg <= wp_meta_reg;
         cs_meta_reg <= CHIP_SELECT_STRAPS;
         cs_sync_reg <= cs_meta_reg;
      end
   end

   // Data may only move with clock low, so a data edge at clock high is
   // a bus condition rather than a bit
   assign scl_rise = scl_sync_reg & ~scl_prev_reg;
   assign scl_fall = ~scl_sync_reg & scl_prev_reg;
   assign start_cond = scl_sync_reg & scl_prev_reg & sda_prev_reg &
      ~sda_sync_reg;
   assign stop_cond = scl_sync_reg & scl_prev_reg & ~sda_prev_reg &
      sda_sync_reg;
   assign protect = wp_seen_reg &&
      waddr_reg[ADDR_W-1 -: 2] == eep_pkg::TOP_QTR;

   ////////////////////////////////////////////////////////////////////////////
   // Protocol and programming sequencer

   // Next-state logic for the whole engine
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      in_ack_next = in_ack_reg;
      ack_bit_next = ack_bit_reg;
      shift_next = shift_reg;
      tx_next = tx_reg;
      oe_next = oe_reg;
      rw_next = rw_reg;
      addr_hi_next = addr_hi_reg;
      waddr_next = waddr_reg;
      rd_cnt_next = rd_cnt_reg;
      valid_next = valid_reg;
      wp_seen_next = wp_seen_reg;
      slot10_next = slot10_reg;
      prog_idx_next = prog_idx_reg;
      pw_go_next = 1'b0;
      pw_idx_next = pw_idx_reg;
      wait_next = wait_reg;
      pb_we = 1'b0;
      pb_waddr = waddr_reg[PW-1:0];
      pb_wdata = shift_reg;
      mem_we = 1'b0;
      mem_waddr = {waddr_reg[ADDR_W-1:PW], pw_idx_reg};
      // Protect level is collected from start to the end of the address
      if (state_reg == eep_pkg::ST_DEVSEL || state_reg == eep_pkg::ST_ADDR_HI ||
            state_reg == eep_pkg::ST_ADDR_LO) begin
         wp_seen_next = wp_seen_reg | wp_sync_reg;
      end
      if (state_reg == eep_pkg::ST_PROG) begin
         // Bus is deaf and released; no select is answered here
         oe_next = 1'b0;
         if (prog_idx_reg < PB[PW:0]) begin
            prog_idx_next = prog_idx_reg + 1'b1;
            pw_go_next = 1'b1;
            pw_idx_next = prog_idx_reg[PW-1:0];
         end
         // Latched row bytes go out one per clock; protected ones are dropped
         if (pw_go_reg && valid_reg[pw_idx_reg] && !protect) begin
            mem_we = 1'b1;
         end
         if (prog_idx_reg == PB[PW:0] && !pw_go_reg) begin
            wait_next = wait_reg + 1'b1;
            if (wait_reg == WR_CYCLES[WW-1:0] - 1'b1) begin
               state_next = eep_pkg::ST_IDLE;
            end
         end
      end else if (start_cond) begin
         // Repeated start drops any unfinished page
         state_next = eep_pkg::ST_DEVSEL;
         cnt_next = 4'h0;
         in_ack_next = 1'b0;
         oe_next = 1'b0;
         valid_next = '0;
         slot10_next = 1'b0;
         wp_seen_next = wp_sync_reg;
      end else if (stop_cond) begin
         oe_next = 1'b0;
         prog_idx_next = '0;
         wait_next = '0;
         if (state_reg == eep_pkg::ST_WDATA && slot10_reg && |valid_reg) begin
            state_next = eep_pkg::ST_PROG;
         end else begin
            state_next = eep_pkg::ST_IDLE;
         end
      end else if (state_reg != eep_pkg::ST_IDLE) begin
         if (scl_rise) begin
            // The stop's own clock rise must not close the tenth slot
            slot10_next = slot10_reg && cnt_reg == 4'h0;
            if (cnt_reg < eep_pkg::BYTE_BITS) begin
               shift_next = {shift_reg[6:0], sda_sync_reg};
               cnt_next = cnt_reg + 1'b1;
            end else begin
               ack_bit_next = sda_sync_reg;
            end
         end else if (scl_fall && cnt_reg == eep_pkg::BYTE_BITS &&
               !in_ack_reg) begin
            // Eight bits done: enter the acknowledge slot
            in_ack_next = 1'b1;
            oe_next = 1'b1;
            unique case (state_reg)
               eep_pkg::ST_DEVSEL: begin
                  rw_next = shift_reg[0];
                  if (shift_reg[7:4] != DEV_TYPE ||
                        shift_reg[3:1] != cs_sync_reg) begin
                     oe_next = 1'b0;
                     state_next = eep_pkg::ST_IDLE;
                  end
               end
               eep_pkg::ST_ADDR_HI: begin
                  addr_hi_next = shift_reg;
               end
               eep_pkg::ST_ADDR_LO: begin
                  // Address becomes the read counter for a random read
                  waddr_next = {addr_hi_reg, shift_reg};
                  rd_cnt_next = ADDR_W'({addr_hi_reg, shift_reg});
               end
               eep_pkg::ST_WDATA: begin
                  pb_we = 1'b1;
                  valid_next[waddr_reg[PW-1:0]] = 1'b1;
               end
               eep_pkg::ST_RDATA: begin
                  oe_next = 1'b0;
                  rd_cnt_next = rd_cnt_reg + 1'b1;
               end
               eep_pkg::ST_IDLE, eep_pkg::ST_PROG: begin
                  oe_next = 1'b0;
               end
            endcase
         end else if (scl_fall && in_ack_reg) begin
            // End of the ninth slot: release and move to the next byte
            in_ack_next = 1'b0;
            cnt_next = 4'h0;
            oe_next = 1'b0;
            unique case (state_reg)
               eep_pkg::ST_DEVSEL: begin
                  if (rw_reg) begin
                     state_next = eep_pkg::ST_RDATA;
                     tx_next = mem_rdata;
                     oe_next = ~mem_rdata[7];
                  end else begin
                     state_next = eep_pkg::ST_ADDR_HI;
                  end
               end
               eep_pkg::ST_ADDR_HI: begin
                  state_next = eep_pkg::ST_ADDR_LO;
               end
               eep_pkg::ST_ADDR_LO: begin
                  state_next = eep_pkg::ST_WDATA;
               end
               eep_pkg::ST_WDATA: begin
                  // Row bits hold still; only the low bits wrap
                  waddr_next[PW-1:0] = waddr_reg[PW-1:0] + 1'b1;
                  slot10_next = 1'b1;
               end
               eep_pkg::ST_RDATA: begin
                  if (!ack_bit_reg) begin
                     tx_next = mem_rdata;
                     oe_next = ~mem_rdata[7];
                  end else begin
                     state_next = eep_pkg::ST_IDLE;
                  end
               end
               eep_pkg::ST_IDLE, eep_pkg::ST_PROG: begin
                  state_next = eep_pkg::ST_IDLE;
               end
            endcase
         end else if (scl_fall && state_reg == eep_pkg::ST_RDATA &&
               cnt_reg != 4'h0 && cnt_reg < eep_pkg::BYTE_BITS) begin
            // Next read bit, MSB first, pulled low for a zero
            oe_next = ~tx_reg[~cnt_reg[2:0]];
         end
      end
   end

   assign busy_next = state_next == eep_pkg::ST_PROG;

   // State registers of the engine
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state_reg <= eep_pkg::ST_IDLE;
         cnt_reg <= 4'h0;
         in_ack_reg <= 1'b0;
         ack_bit_reg <= 1'b1;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         oe_reg <= 1'b0;
         rw_reg <= 1'b0;
         addr_hi_reg <= 8'h00;
         waddr_reg <= 16'h0000;
         rd_cnt_reg <= '0;
         valid_reg <= '0;
         wp_seen_reg <= 1'b0;
         slot10_reg <= 1'b0;
         prog_idx_reg <= '0;
         pw_go_reg <= 1'b0;
         pw_idx_reg <= '0;
         wait_reg <= '0;
         busy_reg <= 1'b0;
         sda_out_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         in_ack_reg <= in_ack_next;
         ack_bit_reg <= ack_bit_next;
         shift_reg <= shift_next;
         tx_reg <= tx_next;
         oe_reg <= oe_next;
         rw_reg <= rw_next;
         addr_hi_reg <= addr_hi_next;
         waddr_reg <= waddr_next;
         rd_cnt_reg <= rd_cnt_next;
         valid_reg <= valid_next;
         wp_seen_reg <= wp_seen_next;
         slot10_reg <= slot10_next;
         prog_idx_reg <= prog_idx_next;
         pw_go_reg <= pw_go_next;
         pw_idx_reg <= pw_idx_next;
         wait_reg <= wait_next;
         busy_reg <= busy_next;
         sda_out_reg <= 1'b0; // Open drain: only ever pulls low
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Page latch and array

   // Bytes wait here until a valid stop, so aborted writes never reach
   // the array
   eep_mem #(.AW(PW), .DW(8), .INIT(8'h00)) u_page (
      .clk(CLK),
      .we(pb_we),
      .waddr(pb_waddr),
      .wdata(pb_wdata),
      .raddr(prog_idx_reg[PW-1:0]),
      .rdata(pb_rdata)
   );

   // Array read address follows the read counter continuously
   eep_mem #(.AW(ADDR_W), .DW(8), .INIT(eep_pkg::MEM_INIT)) u_array (
      .clk(CLK),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(pb_rdata),
      .raddr(rd_cnt_reg),
      .rdata(mem_rdata)
   );

   assign SDA_OUT = sda_out_reg;
   assign SDA_OE = oe_reg;
   assign BUSY = busy_reg;
endmodule : eep_slave

/* eep_master_model.sv */
// Behavioural two-wire bus master that drives the serial clock and data
`timescale 1ns/10ps
module eep_master_model (
   // System clock paces every bus edge
   input wire logic clk,
   // Bus wires, data is open drain
   input wire logic sda,
   output logic scl,
   output logic m_oe
);
   ////////////////////////////////////////////////////////////////////////
   // Idle bus: clock parked high between frames, data released
   initial begin
      scl = 1'b1;
      m_oe = 1'b0;
   end
   // Wait whole system clock cycles, half a bit is four
   task automatic hp(input int n);
      repeat (n) @(posedge clk);
   endtask : hp
   // Start, or repeated start when entered in mid low phase
   task automatic start();
      if (!scl) begin
         m_oe <= 1'b0;
         hp(2);
         scl <= 1'b1;
         hp(4);
      end
      m_oe <= 1'b1;
      hp(4);
      scl <= 1'b0;
      hp(2);
   endtask : start
   // Stop leaves the clock standing high
   task automatic stop();
      m_oe <= 1'b1;
      hp(2);
      scl <= 1'b1;
      hp(4);
      m_oe <= 1'b0;
      hp(4);
   endtask : stop
   // One bit slot; data moves only in mid low phase, read late in high
   task automatic bit_io(input logic b, output logic r);
      m_oe <= ~b;
      hp(2);
      scl <= 1'b1;
      hp(3);
      #1 r = sda;
      hp(1);
      scl <= 1'b0;
      hp(2);
   endtask : bit_io
   // Byte out, MSB first, then let go for the acknowledge slot
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask : wr_byte
   // Byte in; acknowledge asks for more, no acknowledge ends the stream
   task automatic rd_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(~ack, r);
   endtask : rd_byte
endmodule : eep_master_model

/* eep_slave_sva.sv */
// Concurrent checks on the serial EEPROM slave engine ports
`timescale 1ns/10ps
module eep_slave_sva #(
   parameter int WR_CYCLES = 200
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Serial bus
   input wire logic SCL,
   input wire logic SDA_IN,
   input wire logic SDA_OUT,
   input wire logic SDA_OE,
   // Straps, protect and status
   input wire logic [2:0] CHIP_SELECT_STRAPS,
   input wire logic WRITE_PROTECT_INPUT,
   input wire logic BUSY
);
   logic scl_reg, sda_reg;
   logic [3:0] fall_cnt_reg, fall_cnt_next, stop_cnt_reg, stop_cnt_next;
   logic [19:0] busy_cnt_reg, busy_cnt_next;
   ////////////////////////////////////////////////////////////////////////
   // Ages of the last clock fall and stop, saturating so old events fade
   always_comb begin
      fall_cnt_next = fall_cnt_reg + {3'h0, fall_cnt_reg != 4'hF};
      stop_cnt_next = stop_cnt_reg + {3'h0, stop_cnt_reg != 4'hF};
      busy_cnt_next = BUSY ? busy_cnt_reg + 20'h1 : 20'h0;
      if (scl_reg && !SCL) fall_cnt_next = 4'h0;
      if (scl_reg && SCL && !sda_reg && SDA_IN) stop_cnt_next = 4'h0;
      if (!RST_N) begin
         fall_cnt_next = 4'hF;
         stop_cnt_next = 4'hF;
         busy_cnt_next = 20'h0;
      end
   end
   // Helper registers
   always_ff @(posedge CLK) begin
      scl_reg <= SCL;
      sda_reg <= SDA_IN;
      fall_cnt_reg <= fall_cnt_next;
      stop_cnt_reg <= stop_cnt_next;
      busy_cnt_reg <= busy_cnt_next;
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   ////////////////////////////////////////////////////////////////////////
   // Open drain: the output value is always low
   property p_out_low; SDA_OUT == 1'b0; endproperty
   a_out_low: assert property (p_out_low)
      else $error("data output value not low");
   // Data wire is taken only shortly after a clock fall
   property p_oe_rise; $rose(SDA_OE) |-> fall_cnt_reg inside {[1:7]};
   endproperty
   a_oe_rise: assert property (p_oe_rise)
      else $error("data drive began away from a clock fall");
   // Release also follows a clock fall
   property p_oe_fall; $fell(SDA_OE) |-> fall_cnt_reg inside {[1:7]};
   endproperty
   a_oe_fall: assert property (p_oe_fall)
      else $error("data release away from a clock fall");
   // A stop leaves the data wire free
   property p_stop_rel; stop_cnt_reg == 4'h0 |-> !SDA_OE [*6]; endproperty
   a_stop_rel: assert property (p_stop_rel)
      else $error("data driven after stop");
   // Programming only begins right after a stop
   property p_busy_src; $rose(BUSY) |-> stop_cnt_reg <= 4'h7; endproperty
   a_busy_src: assert property (p_busy_src)
      else $error("write cycle began without a stop");
   // Never drives the wire while programming
   property p_busy_quiet; BUSY |-> !SDA_OE; endproperty
   a_busy_quiet: assert property (p_busy_quiet)
      else $error("data driven during write cycle");
   // Write cycle lasts its full length
   property p_busy_min; $fell(BUSY) |-> busy_cnt_reg >= WR_CYCLES;
   endproperty
   a_busy_min: assert property (p_busy_min)
      else $error("write cycle ended early");
   // Write cycle does end, so polling is answered again
   property p_busy_max; busy_cnt_reg <= WR_CYCLES + 100; endproperty
   a_busy_max: assert property (p_busy_max)
      else $error("write cycle did not end");
   // Reset puts the engine in standby
   property p_rst_idle; disable iff (1'b0) !RST_N |=> !SDA_OE && !BUSY;
   endproperty
   a_rst_idle: assert property (p_rst_idle)
      else $error("not in standby after reset");
endmodule : eep_slave_sva
bind eep_slave eep_slave_sva #(.WR_CYCLES(WR_CYCLES)) i_eep_slave_sva (
   .CLK(CLK), .RST_N(RST_N), .SCL(SCL), .SDA_IN(SDA_IN),
   .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .BUSY(BUSY),
   .CHIP_SELECT_STRAPS(CHIP_SELECT_STRAPS),
   .WRITE_PROTECT_INPUT(WRITE_PROTECT_INPUT));

/* eep_slave_tb_top.sv */
// Self-checking bench for the serial EEPROM slave engine
`timescale 1ns/10ps
module eep_slave_tb_top;
   localparam int WR_CYC = 200;
   // Device type code under test; value is arbitrary
   localparam logic [3:0] TYPE_ID = 4'hC;
   localparam logic [2:0] STRAPS = 3'h5;
   logic clk, rst_n, scl, sda, sda_out, sda_oe, wp, busy, m_oe;
   logic [2:0] straps;
   int err_count, cmp_count;
   ////////////////////////////////////////////////////////////////////////
   // Open drain data wire with pull-up
   assign sda = ~(sda_oe | m_oe);
   eep_slave #(.WR_CYCLES(WR_CYC), .DEV_TYPE(TYPE_ID)) i_eep_slave (
      .CLK(clk), .RST_N(rst_n), .SCL(scl), .SDA_IN(sda),
      .SDA_OUT(sda_out), .SDA_OE(sda_oe), .CHIP_SELECT_STRAPS(straps),
      .WRITE_PROTECT_INPUT(wp), .BUSY(busy));
   eep_master_model i_eep_master_model (
      .clk(clk), .sda(sda), .scl(scl), .m_oe(m_oe));
   // Clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Verdict and end of run
   task automatic wrap_up();
      $display("Compares %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up
   // Compare one value and count it
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   // Select byte of this device
   function automatic logic [7:0] sel(input logic rw);
      return {TYPE_ID, STRAPS, rw};
   endfunction : sel
   // Bounded wait for the write cycle to finish
   task automatic wait_idle();
      int n;
      n = 0;
      repeat (4) @(posedge clk);
      while (busy !== 1'b0 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      if (busy !== 1'b0) begin
         chk("write cycle end", 8'h0, {7'h0, busy});
         wrap_up();
      end
   endtask : wait_idle
   // Start, then select and address bytes as a write
   task automatic set_addr(input logic [15:0] a);
      logic ack;
      i_eep_master_model.start();
      i_eep_master_model.wr_byte(sel(1'b0), ack);
      chk("select ack", 8'h1, {7'h0, ack});
      i_eep_master_model.wr_byte(a[15:8], ack);
      chk("addr hi ack", 8'h1, {7'h0, ack});
      i_eep_master_model.wr_byte(a[7:0], ack);
      chk("addr lo ack", 8'h1, {7'h0, ack});
   endtask : set_addr
   // Page write of n bytes, low byte first; polls when programming
   task automatic wr_page(input logic [15:0] a, input logic [23:0] d,
                          input int n, input logic prog);
      logic ack;
      set_addr(a);
      for (int i = 0; i < n; i++) begin
         i_eep_master_model.wr_byte(d[8*i +: 8], ack);
         chk("data ack", 8'h1, {7'h0, ack});
      end
      i_eep_master_model.stop();
      if (prog) begin
         repeat (8) @(posedge clk);
         chk("busy after stop", 8'h1, {7'h0, busy});
         i_eep_master_model.start();
         i_eep_master_model.wr_byte(sel(1'b0), ack);
         chk("poll while busy", 8'h0, {7'h0, ack});
         i_eep_master_model.stop();
      end
      wait_idle();
      i_eep_master_model.start();
      i_eep_master_model.wr_byte(sel(1'b0), ack);
      chk("poll when done", 8'h1, {7'h0, ack});
      i_eep_master_model.stop();
   endtask : wr_page
   // Random read of n bytes, acknowledging all but the last
   task automatic rd_rand(input logic [15:0] a, input logic [23:0] e,
                          input int n);
      logic ack;
      logic [7:0] d;
      set_addr(a);
      i_eep_master_model.start();
      i_eep_master_model.wr_byte(sel(1'b1), ack);
      chk("read select ack", 8'h1, {7'h0, ack});
      for (int i = 0; i < n; i++) begin
         i_eep_master_model.rd_byte(i < n - 1, d);
         chk("read data", e[8*i +: 8], d);
      end
      i_eep_master_model.stop();
   endtask : rd_rand
   // Wrong type code or one wrong strap bit is never answered
   task automatic t_bad_sel();
      logic ack;
      for (int i = 0; i < 4; i++) begin
         i_eep_master_model.start();
         i_eep_master_model.wr_byte(sel(1'b0) ^ (8'h02 << i), ack);
         chk("foreign select", 8'h0, {7'h0, ack});
         i_eep_master_model.stop();
      end
      chk("busy after foreign", 8'h0, {7'h0, busy});
   endtask : t_bad_sel
   // Three bytes from column 30 wrap into the start of the row
   task automatic t_page();
      wr_page(16'h013E, 24'hA2A1A0, 3, 1'b1);
      rd_rand(16'h013E, 24'hFFA1A0, 3);
      rd_rand(16'h0120, 24'h0000A2, 1);
   endtask : t_page
   // Protect high blocks the top quarter only; reads ignore it
   task automatic t_wp();
      wp <= 1'b1;
      wr_page(16'hF800, 24'h000055, 1, 1'b0);
      wr_page(16'h17FF, 24'h000066, 1, 1'b1);
      rd_rand(16'h17FF, 24'h00FF66, 2);
      wp <= 1'b0;
      rd_rand(16'h1800, 24'h0000FF, 1);
   endtask : t_wp
   // Stop in mid data byte must not program
   task automatic t_abort();
      logic r;
      set_addr(16'h0200);
      for (int i = 0; i < 4; i++) begin
         i_eep_master_model.bit_io(1'b0, r);
      end
      i_eep_master_model.stop();
      repeat (20) @(posedge clk);
      chk("busy after abort", 8'h0, {7'h0, busy});
      rd_rand(16'h0200, 24'h0000FF, 1);
   endtask : t_abort
   // Last address rolls to zero; current read follows the counter
   task automatic t_wrap();
      logic ack;
      logic [7:0] d;
      wr_page(16'h1FFF, 24'h00003C, 1, 1'b1);
      wr_page(16'h0000, 24'h0000C3, 1, 1'b1);
      wp <= 1'b1;
      rd_rand(16'h1FFF, 24'h00C33C, 2);
      rd_rand(16'h1FFF, 24'h00003C, 1);
      i_eep_master_model.start();
      i_eep_master_model.wr_byte(sel(1'b1), ack);
      chk("current select ack", 8'h1, {7'h0, ack});
      i_eep_master_model.rd_byte(1'b0, d);
      chk("current read", 8'hC3, d);
      i_eep_master_model.stop();
      wp <= 1'b0;
   endtask : t_wrap
   // Main sequence
   initial begin
      rst_n = 1'b0;
      wp = 1'b0;
      straps = STRAPS;
      err_count = 0;
      cmp_count = 0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      t_bad_sel();
      t_page();
      t_wp();
      t_abort();
      t_wrap();
      wrap_up();
   end
endmodule : eep_slave_tb_top
